// ===== kcs_keys.sv
// kcs_keys: passive 8x8 switch matrix
// rows are pulled low, so an open row reads 0
`timescale 1ns/1ps
`default_nettype none
module kcs_keys (
  input  wire logic [7:0]  col_out,
  input  wire logic [7:0]  col_oe_b,
  input  wire logic [63:0] pressed,
  output logic      [7:0]  rows
);
  always_comb begin
    for (int r = 0; r < 8; r++) begin
      rows[r] = |(pressed[r*8+:8] & col_out & ~col_oe_b);
    end
  end
endmodule // kcs_keys
`default_nettype wire

// ===== kcs_pkg.sv
// kcs_pkg: shared types and constants for the keypad column scanner
// assumes a single 125 MHz peripheral clock and an active-low async reset
package kcs_pkg;

  localparam int unsigned KCS_COLS      = 8;
  localparam int unsigned KCS_ROWS      = 8;
  localparam int unsigned KCS_IDX_W     = 3;

  // column drive modes
  typedef enum logic [1:0] {
    KCS_MODE_ALL_HIZ,
    KCS_MODE_ALL_LOW,
    KCS_MODE_ALL_HIGH,
    KCS_MODE_ONE_HIGH
  } kcs_mode_type;

  // power states seen by the wake logic
  typedef enum logic [1:0] {
    KCS_PWR_RUN,
    KCS_PWR_IDLE,
    KCS_PWR_STANDBY
  } kcs_pwr_type;

  typedef struct packed {
    kcs_mode_type         mode;
    logic [KCS_IDX_W-1:0] index;
  } kcs_col_ctrl_type;

  typedef struct packed {
    logic [KCS_COLS-1:0] out;
    logic [KCS_COLS-1:0] oe_b;
  } kcs_col_pins_type;

  localparam kcs_col_ctrl_type KCS_CTRL_RESET = '{mode: KCS_MODE_ALL_HIZ, index: 3'h0};
  localparam logic [KCS_COLS-1:0] KCS_ALL_ONES = 8'hFF;
  localparam logic [KCS_COLS-1:0] KCS_ALL_ZERO = 8'h00;

endpackage

// ===== kcs_row_sync.sv
// kcs_row_sync: two-stage synchroniser for the row sense pins
// assumes the pins are asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module kcs_row_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } kcs_sync_state_type;

  kcs_sync_state_type state_q;
  kcs_sync_state_type state_d;

  always_comb begin
    state_d.meta = pin_in;
    state_d.sync = state_q.meta;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.sync;

endmodule // kcs_row_sync
`default_nettype wire

// ===== kcs_scanner.sv
// kcs_scanner: keypad column driver and row wake/interrupt logic
// assumes software control arrives on the same clock; row pins are async
// Contract
// - eight column drive lines, one per column
// - one chosen column high, others hi-z
// - global modes: all low, high, hi-z
// - selected input rows ORed into interrupt
// - keyboard interrupt wakes from idle, standby
// - columns and rows scan 8x8 matrix
// - idle halts processor clock only
// - standby stops oscillator, key still wakes
`timescale 1ns/1ps
`default_nettype none
module kcs_scanner #(
  parameter int unsigned COLS = kcs_pkg::KCS_COLS,
  parameter int unsigned ROWS = kcs_pkg::KCS_ROWS
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  // software column control
  input  wire kcs_pkg::kcs_col_ctrl_type col_ctrl,
  input  wire logic                      col_ctrl_we,
  // row port setup
  input  wire logic [ROWS-1:0]           row_is_input,
  input  wire logic [ROWS-1:0]           row_select,
  // power state request
  input  wire kcs_pkg::kcs_pwr_type      pwr_req,
  input  wire logic                      pwr_req_we,
  // key matrix pins
  output kcs_pkg::kcs_col_pins_type      col_pins,
  input  wire logic [ROWS-1:0]           row_sense_in,
  // status
  output logic                           key_irq,
  output logic                           cpu_clk_en,
  output logic                           osc_en,
  output logic                           wake_pulse,
  output logic [ROWS-1:0]                row_state,
  output kcs_pkg::kcs_pwr_type           pwr_state
);

  // decode and mode constants are fixed at eight lines each way
  if (COLS != kcs_pkg::KCS_COLS || ROWS != kcs_pkg::KCS_ROWS) begin : g_bad_size
    $error("kcs_scanner supports only an 8x8 matrix");
  end

  typedef struct packed {
    kcs_pkg::kcs_col_ctrl_type ctrl;
    kcs_pkg::kcs_col_pins_type pins;
    kcs_pkg::kcs_pwr_type      pwr;
    logic                      irq;
    logic                      wake;
    logic [ROWS-1:0]           rows;
  } kcs_state_type;

  kcs_state_type state_q;
  kcs_state_type state_d;
  logic [ROWS-1:0] rows_sync;
  logic [COLS-1:0] one_hot;
  logic            key_any;
  // next control kept apart so the decode does not loop through state_d
  kcs_pkg::kcs_col_ctrl_type ctrl_next;

  assign ctrl_next = col_ctrl_we ? col_ctrl : state_q.ctrl;

  // pins are async: two flops before use
  kcs_row_sync #(
    .WIDTH (ROWS)
  ) u_row_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .pin_in   (row_sense_in),
    .sync_out (rows_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < COLS; gi++) begin : g_col
      assign one_hot[gi] = (ctrl_next.index == kcs_pkg::KCS_IDX_W'(gi));
    end
  endgenerate

  assign key_any = |(rows_sync & row_is_input & row_select);

  always_comb begin
    state_d = state_q;
    state_d.rows = rows_sync;
    state_d.ctrl = ctrl_next;
    unique case (state_d.ctrl.mode)
      kcs_pkg::KCS_MODE_ALL_HIZ: begin
        state_d.pins.out  = kcs_pkg::KCS_ALL_ZERO;
        state_d.pins.oe_b = kcs_pkg::KCS_ALL_ONES;
      end
      kcs_pkg::KCS_MODE_ALL_LOW: begin
        state_d.pins.out  = kcs_pkg::KCS_ALL_ZERO;
        state_d.pins.oe_b = kcs_pkg::KCS_ALL_ZERO;
      end
      kcs_pkg::KCS_MODE_ALL_HIGH: begin
        state_d.pins.out  = kcs_pkg::KCS_ALL_ONES;
        state_d.pins.oe_b = kcs_pkg::KCS_ALL_ZERO;
      end
      kcs_pkg::KCS_MODE_ONE_HIGH: begin
        state_d.pins.out  = one_hot;
        state_d.pins.oe_b = ~one_hot;
      end
    endcase
    state_d.irq  = key_any;
    state_d.wake = 1'b0;
    if (pwr_req_we) begin
      state_d.pwr = pwr_req;
    end
    // key wins over a sleep request
    if (key_any && state_d.pwr != kcs_pkg::KCS_PWR_RUN) begin
      state_d.pwr  = kcs_pkg::KCS_PWR_RUN;
      state_d.wake = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q.ctrl <= kcs_pkg::KCS_CTRL_RESET;
      state_q.pins <= '{out: kcs_pkg::KCS_ALL_ZERO, oe_b: kcs_pkg::KCS_ALL_ONES};
      state_q.pwr  <= kcs_pkg::KCS_PWR_RUN;
      state_q.irq  <= 1'b0;
      state_q.wake <= 1'b0;
      state_q.rows <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign col_pins   = state_q.pins;
  assign row_state  = state_q.rows;
  assign key_irq    = state_q.irq;
  assign wake_pulse = state_q.wake;
  assign pwr_state  = state_q.pwr;
  assign cpu_clk_en = (state_q.pwr == kcs_pkg::KCS_PWR_RUN);
  assign osc_en     = (state_q.pwr != kcs_pkg::KCS_PWR_STANDBY);

endmodule // kcs_scanner
`default_nettype wire

// ===== kcs_scanner_assertions.sv
// kcs_chk: port checks on kcs_scanner
// row setup held still while keys are read
`timescale 1ns/1ps
`default_nettype none
module kcs_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire kcs_pkg::kcs_col_ctrl_type col_ctrl,
  input wire logic col_ctrl_we,
  input wire logic [7:0] row_is_input,
  input wire logic [7:0] row_select,
  input wire logic [7:0] row_sense_in,
  input wire kcs_pkg::kcs_col_pins_type col_pins,
  input wire logic key_irq,
  input wire logic cpu_clk_en,
  input wire logic osc_en,
  input wire logic wake_pulse,
  input wire kcs_pkg::kcs_pwr_type pwr_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [3:0] w;
  logic [7:0] en;
  // one bit per mode written
  assign w = {4{col_ctrl_we}} & (4'h1 << col_ctrl.mode);
  assign en = row_sense_in & row_select & row_is_input;
  a_one_high: assert property (w[3] |=> col_pins.oe_b == ~(8'h01 << $past(col_ctrl.index)))
    else $error("one high");
  a_all_low: assert property (w[1] |=> col_pins == 16'h0000) else $error("all low");
  a_all_high: assert property (w[2] |=> col_pins == 16'hFF00) else $error("all high");
  a_all_hiz: assert property (w[0] |=> col_pins.oe_b == 8'hFF) else $error("all hiz");
  a_irq_set: assert property (en != 8'h00 [*4] |=> key_irq) else $error("irq set");
  a_irq_clr: assert property (en == 8'h00 [*4] |=> !key_irq) else $error("irq clr");
  a_wake_run: assert property (wake_pulse |-> cpu_clk_en ##1 !wake_pulse)
    else $error("wake");
  a_sleep_clk: assert property (pwr_state != kcs_pkg::KCS_PWR_RUN |-> !cpu_clk_en
    && osc_en == (pwr_state == kcs_pkg::KCS_PWR_IDLE)) else $error("sleep clocks");
  c_wake: cover property (wake_pulse);
  c_stby: cover property (pwr_state == kcs_pkg::KCS_PWR_STANDBY);
  c_scan: cover property (key_irq && w[3]);
endmodule // kcs_chk
bind kcs_scanner kcs_chk chk_u (.*);
`default_nettype wire

// ===== kcs_scanner_tb.sv
// kcs_scanner_tb: directed tests of the scanner
// the switch model drives the row pins
`timescale 1ns/1ps
`default_nettype none
module kcs_scanner_tb;
  logic clock = 0, rst_b = 0, col_ctrl_we = 0, pwr_req_we = 0;
  logic key_irq, cpu_clk_en, osc_en, wake_pulse;
  logic [7:0] row_is_input = 8'hFF, row_select = 8'hFF, row_sense_in, row_state;
  logic [63:0] keys = 64'h0;
  logic [15:0] drv;
  kcs_pkg::kcs_col_ctrl_type col_ctrl = kcs_pkg::KCS_CTRL_RESET;
  kcs_pkg::kcs_pwr_type pwr_req = kcs_pkg::KCS_PWR_RUN, pwr_state;
  kcs_pkg::kcs_col_pins_type col_pins;
  int failures = 0, check_count = 0, cyc = 0;
  always #4 clock = ~clock;
  // driven view: enables, then levels of driven lines
  assign drv = {col_pins.oe_b, col_pins.out & ~col_pins.oe_b};
  kcs_scanner dut_u (
    .clock        (clock),
    .rst_b        (rst_b),
    .col_ctrl     (col_ctrl),
    .col_ctrl_we  (col_ctrl_we),
    .row_is_input (row_is_input),
    .row_select   (row_select),
    .pwr_req      (pwr_req),
    .pwr_req_we   (pwr_req_we),
    .col_pins     (col_pins),
    .row_sense_in (row_sense_in),
    .key_irq      (key_irq),
    .cpu_clk_en   (cpu_clk_en),
    .osc_en       (osc_en),
    .wake_pulse   (wake_pulse),
    .row_state    (row_state),
    .pwr_state    (pwr_state)
  );
  kcs_keys mat_u (.col_out(col_pins.out), .col_oe_b(col_pins.oe_b), .pressed(keys),
    .rows(row_sense_in));
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cols(int m, int i);
    col_ctrl = '{kcs_pkg::kcs_mode_type'(m), 3'(i)};
    col_ctrl_we = 1;
    tick(1);
  endtask
  task automatic t_cols();
    logic [15:0] e;
    chk("reset pins", 16'hFF00, drv);
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 8; i++) begin
        e = m == 0 ? 16'hFF00 : m == 1 ? 16'h0000 : m == 2 ? 16'h00FF : {~(8'h01 << i), 8'h01 << i};
        cols(m, i);
        chk("col drive", e, drv);
      end
    end
    col_ctrl_we = 0;
    $display("column test done");
  endtask
  task automatic t_scan();
    keys[21] = 1;
    tick(1);
    cols(3, 5);
    col_ctrl_we = 0;
    tick(5);
    chk("key hit", 16'h0401, {row_state, 7'h0, key_irq});
    row_select = 8'hFB;
    tick(5);
    chk("row masked", 16'h0000, {15'h0, key_irq});
    row_select = 8'hFF;
    cols(3, 4);
    col_ctrl_we = 0;
    tick(5);
    chk("other col", 16'h0000, {row_state, 7'h0, key_irq});
    $display("scan test done");
  endtask
  task automatic t_wake(kcs_pkg::kcs_pwr_type p, logic [1:0] e);
    keys = 64'h0;
    cols(2, 0);
    col_ctrl_we = 0;
    pwr_req = p;
    tick(5);
    pwr_req_we = 1;
    tick(1);
    pwr_req_we = 0;
    tick(2);
    chk("asleep", {14'h0, e}, {14'h0, cpu_clk_en, osc_en});
    keys[0] = 1;
    for (int k = 0; k < 10 && wake_pulse !== 1'b1; k++)
      tick(1);
    chk("woken", 16'h0007, {13'h0, wake_pulse, cpu_clk_en, osc_en});
    chk("woken state", {14'h0, kcs_pkg::KCS_PWR_RUN}, {14'h0, pwr_state});
    tick(1);
    chk("wake once", 16'h0000, {15'h0, wake_pulse});
    // key still held: a sleep request is refused at once
    pwr_req_we = 1;
    tick(1);
    pwr_req_we = 0;
    chk("sleep refused", {13'h0, 1'b1, kcs_pkg::KCS_PWR_RUN}, {13'h0, wake_pulse, pwr_state});
    tick(1);
    chk("refuse once", 16'h0000, {15'h0, wake_pulse});
    $display("wake test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    tick(8);
    rst_b = 1;
    t_cols();
    t_scan();
    t_wake(kcs_pkg::KCS_PWR_IDLE, 2'b01);
    t_wake(kcs_pkg::KCS_PWR_STANDBY, 2'b00);
    end_sim();
  end
endmodule // kcs_scanner_tb
`default_nettype wire
